// [fpp_pkg.sv]
// Package: register map, reset values and bus codes for the four-pin port.
// Assumes one 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package fpp_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [4:0] OFS_DIR  = 5'h00;  // direction_control
  localparam logic [4:0] OFS_PIN  = 5'h04;  // pin_input_level
  localparam logic [4:0] OFS_LAT  = 5'h08;  // output_latch
  localparam logic [4:0] OFS_ANSL = 5'h0C;  // analog_select_low
  localparam logic [4:0] OFS_ANSH = 5'h10;  // analog_select_high
  localparam logic [4:0] OFS_CFG  = 5'h14;  // config_word_three_high

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int BIDIR_N     = 3;   // bidirectional pins
  localparam int REG_W       = 8;   // register width
  localparam int PIN_IN_BIT  = 3;   // input_only_pin in pin_input_level
  localparam int ANSL_LSB    = 6;   // analog_sel_six, analog_sel_seven
  localparam int ANSH_BIT    = 0;   // analog_sel_eight
  localparam int MC_EN_BIT   = 7;   // master_clear_enable_cfg

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] DIR_RST  = 3'h7;
  localparam logic [2:0] LAT_RST  = 3'h0;
  localparam logic [7:0] ANSL_RST = 8'hFF;
  localparam logic       ANSH_RST = 1'b1;
  localparam logic       CFG_RST  = 1'b1;

  // ****************************************************************
  // Bus codes
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

endpackage

// [fpp_reg_if.sv]
// Interface: register access strobes between the bus slave and the port.
// Assumes both ends run on the same clock.
interface fpp_reg_if;
  logic        wr_stb;
  logic [4:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane0;
  logic        wr_hit;
  logic [4:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;

  modport bus  (output wr_stb, wr_addr, wr_data, wr_lane0, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_stb, wr_addr, wr_data, wr_lane0, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface

// [fpp_axil_slave.sv]
// AXI4-Lite slave: takes write address and data in either order,
// issues one write strobe, and answers reads from the register mux.
// Assumes a master that holds valid and payload until taken.
module fpp_axil_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write address and data
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  // Write response
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // Read
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // Register side
  fpp_reg_if.bus           regs
);

  logic        aw_held_reg;
  logic [4:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic        w_lane0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire ar_take = arvalid && arready;

  assign awready       = !aw_held_reg;
  assign wready        = !w_held_reg;
  assign arready       = !rvalid_reg;
  assign bvalid        = bvalid_reg;
  assign bresp         = bresp_reg;
  assign rvalid        = rvalid_reg;
  assign rdata         = rdata_reg;
  assign rresp         = rresp_reg;
  assign regs.wr_stb   = wr_fire;
  assign regs.wr_addr  = aw_addr_reg;
  assign regs.wr_data  = w_data_reg;
  assign regs.wr_lane0 = w_lane0_reg;
  assign regs.rd_addr  = araddr;

  // ****************************************************************
  // Write channels
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= fpp_pkg::ZERO_WORD;
      w_lane0_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= wdata;
        w_lane0_reg <= wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= fpp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= regs.wr_hit ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= fpp_pkg::ZERO_WORD;
      rresp_reg  <= fpp_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= regs.rd_data;
      rresp_reg  <= regs.rd_hit ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// [fpp_port.sv]
// Top: four-pin port with three bidirectional pins sharing analog inputs
// and one input-only pin that may serve as the master clear input.
// Assumes synchronous pin inputs and an AXI4-Lite master.
module fpp_port #(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Bidirectional pins
  input  wire logic [2:0]  port_pin_i,
  output      logic [2:0]  port_pin_o,
  output      logic [2:0]  port_pin_oe_n,
  // Input-only pin and master clear
  input  wire logic        input_only_pin,
  output      logic        master_clear_req,
  // Converter channel enables: six, seven, eight
  output      logic [2:0]  analog_en
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (ADDR_W != 5) begin : g_chk
    $error("fpp_port: ADDR_W must be 5");
  end

  fpp_reg_if regs ();

  fpp_axil_slave u_slave (
    .clk     (clk),
    .rst_n   (rst_n),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs.bus)
  );

  logic [2:0] dir_reg;
  logic [2:0] lat_reg;
  logic [7:0] ansl_reg;
  logic       ansh_reg;
  logic       mc_en_reg;
  logic       mc_req_reg;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire wr_ok   = regs.wr_stb && regs.wr_lane0;
  wire wr_dir  = wr_ok && (regs.wr_addr == fpp_pkg::OFS_DIR);
  // A write to the pin register lands in the latch
  wire wr_lat  = wr_ok && ((regs.wr_addr == fpp_pkg::OFS_LAT) ||
                           (regs.wr_addr == fpp_pkg::OFS_PIN));
  wire wr_ansl = wr_ok && (regs.wr_addr == fpp_pkg::OFS_ANSL);
  wire wr_ansh = wr_ok && (regs.wr_addr == fpp_pkg::OFS_ANSH);
  wire wr_cfg  = wr_ok && (regs.wr_addr == fpp_pkg::OFS_CFG);

  assign regs.wr_hit = (regs.wr_addr == fpp_pkg::OFS_DIR)  ||
                       (regs.wr_addr == fpp_pkg::OFS_PIN)  ||
                       (regs.wr_addr == fpp_pkg::OFS_LAT)  ||
                       (regs.wr_addr == fpp_pkg::OFS_ANSL) ||
                       (regs.wr_addr == fpp_pkg::OFS_ANSH) ||
                       (regs.wr_addr == fpp_pkg::OFS_CFG);

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg  <= fpp_pkg::DIR_RST;
      lat_reg  <= fpp_pkg::LAT_RST;
      ansl_reg <= fpp_pkg::ANSL_RST;
      ansh_reg <= fpp_pkg::ANSH_RST;
    end else begin
      if (wr_dir)
        dir_reg <= regs.wr_data[2:0];
      if (wr_lat)
        lat_reg <= regs.wr_data[2:0];
      if (wr_ansl)
        ansl_reg <= regs.wr_data[7:0];
      if (wr_ansh)
        ansh_reg <= regs.wr_data[fpp_pkg::ANSH_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_en_reg  <= fpp_pkg::CFG_RST;
      mc_req_reg <= 1'b0;
    end else begin
      if (wr_cfg)
        mc_en_reg <= regs.wr_data[fpp_pkg::MC_EN_BIT];
      mc_req_reg <= mc_en_reg && !input_only_pin;
    end
  end

  // ****************************************************************
  // Pin logic
  // ****************************************************************
  assign analog_en = {ansh_reg,
                      ansl_reg[fpp_pkg::ANSL_LSB + 1 -: 2]};
  // Drivers follow direction only; analog selection never masks them
  assign port_pin_oe_n    = dir_reg;
  assign port_pin_o       = lat_reg;
  assign master_clear_req = mc_req_reg;

  wire [2:0] dig_in   = port_pin_i & ~analog_en;
  wire       pin3_in  = input_only_pin && !mc_en_reg;
  wire [7:0] pin_word = {4'h0, pin3_in, dig_in};

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire rd_dir  = regs.rd_addr == fpp_pkg::OFS_DIR;
  wire rd_pin  = regs.rd_addr == fpp_pkg::OFS_PIN;
  wire rd_lat  = regs.rd_addr == fpp_pkg::OFS_LAT;
  wire rd_ansl = regs.rd_addr == fpp_pkg::OFS_ANSL;
  wire rd_ansh = regs.rd_addr == fpp_pkg::OFS_ANSH;
  wire rd_cfg  = regs.rd_addr == fpp_pkg::OFS_CFG;

  wire [7:0] rd_byte =
    rd_dir  ? {5'h00, dir_reg}        :
    rd_pin  ? pin_word                :
    rd_lat  ? {5'h00, lat_reg}        :
    rd_ansl ? ansl_reg                :
    rd_ansh ? {7'h00, ansh_reg}       :
    rd_cfg  ? {mc_en_reg, 7'h00}      :
              8'h00;

  assign regs.rd_data = {24'h00_0000, rd_byte};
  assign regs.rd_hit  = rd_dir || rd_pin || rd_lat || rd_ansl ||
                        rd_ansh || rd_cfg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic first_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  property p_dir_write;
    @(posedge clk) disable iff (!rst_n)
      wr_dir |=> port_pin_oe_n == $past(regs.wr_data[2:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not reach output enables");

  property p_lat_drive;
    @(posedge clk) disable iff (!rst_n)
      (wr_lat && analog_en == 3'h7) |=>
        port_pin_o == $past(regs.wr_data[2:0]);
  endproperty
  a_lat_drive: assert property (p_lat_drive)
    else $error("latch not driven while analog selected");

  property p_analog_zero;
    @(posedge clk) disable iff (!rst_n)
      rd_pin |-> (regs.rd_data[2:0] & analog_en) == 3'h0;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read as nonzero");

  property p_dir_kept;
    @(posedge clk) disable iff (!rst_n)
      (!wr_dir && (wr_ansl || wr_ansh)) |=> $stable(port_pin_oe_n);
  endproperty
  a_dir_kept: assert property (p_dir_kept)
    else $error("analog select changed output enables");

  property p_reset_state;
    @(posedge clk) disable iff (!rst_n)
      first_reg |-> (analog_en == 3'h7 && port_pin_oe_n == 3'h7);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong pin state after reset");

  property p_lat_read;
    @(posedge clk) disable iff (!rst_n)
      rd_lat |-> regs.rd_data == {29'h0000_0000, port_pin_o};
  endproperty
  a_lat_read: assert property (p_lat_read)
    else $error("latch read did not return latch");

  property p_pin3;
    @(posedge clk) disable iff (!rst_n)
      rd_pin |-> regs.rd_data[3] == (input_only_pin && !mc_en_reg);
  endproperty
  a_pin3: assert property (p_pin3)
    else $error("input-only pin bit wrong");

  property p_mc_req;
    @(posedge clk) disable iff (!rst_n)
      (mc_en_reg && !input_only_pin) |=> master_clear_req;
  endproperty
  a_mc_req: assert property (p_mc_req)
    else $error("master clear not raised");

  property p_mc_off;
    @(posedge clk) disable iff (!rst_n)
      !mc_en_reg |=> !master_clear_req;
  endproperty
  a_mc_off: assert property (p_mc_off)
    else $error("master clear raised while pin is a port input");

  property p_pin3_hidden;
    @(posedge clk) disable iff (!rst_n)
      (rd_pin && mc_en_reg) |-> !regs.rd_data[3];
  endproperty
  a_pin3_hidden: assert property (p_pin3_hidden)
    else $error("fourth pin visible while it is master clear");

  property p_lat_follow;
    @(posedge clk) disable iff (!rst_n)
      wr_lat |=> port_pin_o == $past(regs.wr_data[2:0]);
  endproperty
  a_lat_follow: assert property (p_lat_follow)
    else $error("latch write did not reach pin outputs");

  property p_pin_upper;
    @(posedge clk) disable iff (!rst_n)
      rd_pin |-> regs.rd_data[31:4] == 28'h000_0000;
  endproperty
  a_pin_upper: assert property (p_pin_upper)
    else $error("pin register upper bits not zero");

  property p_lat_upper;
    @(posedge clk) disable iff (!rst_n)
      rd_lat |-> regs.rd_data[31:3] == 29'h0000_0000;
  endproperty
  a_lat_upper: assert property (p_lat_upper)
    else $error("latch register shows a fourth-pin bit");

  property p_ansh_map;
    @(posedge clk) disable iff (!rst_n)
      wr_ansh |=> analog_en[2] == $past(regs.wr_data[0]);
  endproperty
  a_ansh_map: assert property (p_ansh_map)
    else $error("analog select high map wrong");

  property p_dir_upper;
    @(posedge clk) disable iff (!rst_n)
      rd_dir |-> regs.rd_data[31:3] == 29'h0000_0000;
  endproperty
  a_dir_upper: assert property (p_dir_upper)
    else $error("direction upper bits not zero");

  property p_ansl_map;
    @(posedge clk) disable iff (!rst_n)
      wr_ansl |=> analog_en[1:0] == $past(regs.wr_data[7:6]);
  endproperty
  a_ansl_map: assert property (p_ansl_map)
    else $error("analog select low map wrong");

endmodule

// [fpp_pin_model.sv]
// Pin model: the board around the four-pin port.
// Assumes the bench sets the levels that outside sources put on the pins.
module fpp_pin_model (
  // Port side
  input  wire logic [2:0] port_pin_o,
  input  wire logic [2:0] port_pin_oe_n,
  // Bench side
  input  wire logic [2:0] ext_level,
  input  wire logic       ext_fourth,
  // Resolved pin levels
  output      logic [2:0] port_pin_i,
  output      logic       input_only_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Outside source yields wherever the port drives, so no contention
  assign port_pin_i = (port_pin_oe_n & ext_level) |
                      (~port_pin_oe_n & port_pin_o);
  assign input_only_pin = ext_fourth;
endmodule

// [tb_top.sv]
// Testbench: drives the port over AXI4-Lite and compares with a model.
// Assumes the pin model resolves the shared pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ext_fourth, iop, mc_req;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pin_i, pin_o, pin_oe_n, analog_en, ext_level;
  int          error_cnt, samples_checked, seed;
  int          m_dir, m_lat, m_ansl, m_ansh, m_cfg;
  int          t_a[13] = '{12, 16, 20, 0, 8, 4, 8, 20, 12, 16, 0, 24, 8};
  int          t_d[13] = '{'h3F, 0, 0, 'hFB, 'hFD, 2, 7, 'h80, 'hC0, 1, 0,
                           'hFF, 5};
  int          t_s[13] = '{15, 15, 1, 1, 1, 1, 0, 1, 1, 1, 1, 1, 1};
  int          t_e[13] = '{5, 5, 5, 5, 2, 2, 2, 2, 7, 7, 0, 0, 3};
  int          t_f[13] = '{1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0};

  fpp_port i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_pin_i(pin_i), .port_pin_o(pin_o),
    .port_pin_oe_n(pin_oe_n), .input_only_pin(iop),
    .master_clear_req(mc_req), .analog_en(analog_en));

  fpp_pin_model i_pins (.port_pin_o(pin_o), .port_pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .ext_fourth(ext_fourth), .port_pin_i(pin_i),
    .input_only_pin(iop));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Model
  // ****************************************************************
  function automatic int m_an();
    return ((m_ansh & 1) << 2) | ((m_ansl >> 6) & 3);
  endfunction

  function automatic logic [31:0] exp_rd(input int a);
    int w;
    w = ((m_dir & ext_level) | (~m_dir & m_lat)) & 7;
    case (a)
      0:  return 32'(m_dir);
      4:  return 32'((w & ~m_an() & 7) | (m_cfg ? 0 : ext_fourth << 3));
      8:  return 32'(m_lat);
      12: return 32'(m_ansl);
      16: return 32'(m_ansh);
      20: return 32'(m_cfg << 7);
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] exp_resp(input int a);
    return 32'((a <= 20) ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR);
  endfunction

  task automatic model_wr(input int a, input int d, input int s);
    if (s & 1) begin
      case (a)
        0:    m_dir = d & 7;
        4, 8: m_lat = d & 7;
        12:   m_ansl = d & 255;
        16:   m_ansh = d & 1;
        20:   m_cfg = (d >> 7) & 1;
        default: ;
      endcase
    end
  endtask

  task automatic model_reset;
    m_dir = 7;
    m_lat = 0;
    m_ansl = int'(fpp_pkg::ANSL_RST);
    m_ansh = 1;
    m_cfg = int'(fpp_pkg::CFG_RST);
  endtask

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic axi_wr(input int a, input int d, input int s);
    logic aw_t, w_t, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= 5'(a);
    wdata <= 32'(d);
    wstrb <= 4'(s);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      aw_done = aw_done | aw_t;
      w_done = w_done | w_t;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    check(32'(bresp), exp_resp(a));
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input int a, output logic [31:0] d,
                        output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge clk);
    araddr <= 5'(a);
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic check_all;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(32'(pin_oe_n), 32'(m_dir));
    check(32'(pin_o), 32'(m_lat));
    check(32'(analog_en), 32'(m_an()));
    check(32'(mc_req), 32'(m_cfg & ~ext_fourth));
    for (int i = 0; i < 32; i += 4) begin
      axi_rd(i, d, r);
      check(d, exp_rd(i));
      check(32'(r), exp_resp(i));
    end
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    model_reset();
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, ext_fourth} = '0;
    {awaddr, araddr, wdata, wstrb, ext_level} = '0;
    seed = 32'ha1745ea4;
    do_reset();
    check_all();
    $display("Test reset values done");
    // Analog pins are made digital before being driven
    // The closing rows drive and write them while analog, on purpose
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      ext_level <= 3'(t_e[i]);
      ext_fourth <= t_f[i][0];
      axi_wr(t_a[i], t_d[i], t_s[i]);
      model_wr(t_a[i], t_d[i], t_s[i]);
      check_all();
    end
    $display("Test directed table done");
    for (int i = 0; i < 30; i++) begin
      int a, d, s;
      a = ($random(seed) & 7) * 4;
      d = $random(seed);
      s = $random(seed);
      @(posedge clk);
      ext_level <= 3'($random(seed));
      ext_fourth <= 1'($random(seed));
      axi_wr(a, d, s);
      model_wr(a, d, s);
      check_all();
    end
    $display("Test random access done");
    do_reset();
    check_all();
    $display("Test second reset done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
